// ===== inc/dma_chan_pkg.sv
// Purpose: constants for the block-transfer channel control logic
// Assumes: 32-bit register port, byte offsets as printed
// Notes:   channel_control_status sits at offset 0x400
package dma_chan_pkg;
	localparam logic [11:0] OFF_CCS   = 12'h400;
	localparam logic [11:0] OFF_PADDR = 12'h404;
	localparam logic [11:0] OFF_CNT   = 12'h408;
	localparam logic [11:0] OFF_LADDR = 12'h40C;
	localparam logic [11:0] OFF_BEC   = 12'h410;
	// channel_control_status fields
	localparam int CCS_GO = 31;
	localparam int CCS_RSTREQ = 30;
	localparam int CCS_ACT = 23;
	localparam int CCS_RSTST = 22;
	localparam int CCS_DONE = 21;
	localparam int CCS_PERR = 20;
	localparam int CCS_QERR = 19;
	localparam int CCS_CMD = 18;
	localparam int CCS_WM_LO = 12;
	localparam int CCS_CODE_LO = 8;
	localparam int CCS_CODE_EN = 7;
	localparam int CCS_CHAIN = 6;
	localparam int CCS_DMA = 5;
	localparam int CCS_DIR = 4;
	localparam int CCS_STYLE = 3;
	localparam int CCS_OWNT = 2;
	localparam int CCS_SLVT = 1;
	localparam int CCS_P16 = 0;
	// block_engine_control fields
	localparam int BEC_CODE_LO = 28;
	localparam int BEC_DIR = 27;
	localparam int BEC_DSZ_LO = 25;
	localparam int BEC_INV = 24;
	localparam int BEC_WM_LO = 20;
	localparam int BEC_OFF_LO = 16;
	localparam int BEC_B4 = 15;
	localparam int BEC_BEN = 14;
	localparam int BEC_MAXB = 9;
	localparam int BEC_CPLOC = 8;
	localparam int BEC_STOP = 7;
	localparam int BEC_STOPST = 6;
	localparam logic [31:0] CCS_RW_MASK = 32'h0004FFFF;
	localparam logic [31:0] BEC_RW_MASK = 32'hF7F7C380;
	localparam logic [31:0] CNT_MASK    = 32'h00FFFFFC;
	localparam logic [31:0] ADDR_MASK   = 32'hFFFFFFFC;
	localparam logic [31:0] LL_CNT_MASK = 32'h000FFFFC;
	localparam logic [31:0] LL_BEC_MASK = 32'hFFF00000;
	localparam logic [23:0] A24_MASK    = 24'hFFFFFF;
	localparam logic [23:0] MIN_COUNT   = 24'h000010;
	localparam logic [23:0] WORD_BYTES  = 24'h000004;
	localparam logic [3:0]  DMA_WM_MAX  = 4'h8;
	localparam logic [7:0]  BLK_256     = 8'hFF;
	localparam logic [7:0]  BLK_64      = 8'h3F;
	localparam logic [1:0]  DSZ_32      = 2'h0;
	localparam logic [1:0]  DSZ_8       = 2'h1;
	localparam logic [1:0]  DSZ_16      = 2'h2;
	localparam logic [1:0]  DSZ_RES     = 2'h3;
	localparam logic [10:0] OFF_CLK_0    = 11'h000;
	localparam logic [10:0] OFF_CLK_64   = 11'h040;
	localparam logic [10:0] OFF_CLK_128  = 11'h080;
	localparam logic [10:0] OFF_CLK_256  = 11'h100;
	localparam logic [10:0] OFF_CLK_512  = 11'h200;
	localparam logic [10:0] OFF_CLK_1024 = 11'h400;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOPPED} chan_state_t;
endpackage

// ===== logic/dma_chan_ctrl.sv
// Purpose: control, address and count logic of the block-transfer channel
// Assumes: one register port shared by both buses; datapath and bus agents outside
// Notes:   strobes from the datapath are one-cycle pulses on ref_clk
//
// Operation
// - handshake mode requests PCI when FIFO holds 16x watermark bytes; zero uses cache line.
// - with code match enabled, acknowledges qualified by matching transaction code lines.
// - engine bit picks handshake or autonomous; chaining bit picks direct or linked list.
// - direction 0 is PCI to local, 1 local to PCI; mirrored read-only.
// - style bit selects older or newer processor handshake.
// - termination bits matter only in older style, dual or single address.
// - in handshake mode, narrow port bit selects 16-bit local port, else 32-bit.
// - reset request aborts an active transfer; ignored while idle.
// - count expiry, or end-of-transfer input in handshake mode, sets done, returns idle, clears active.
// - PCI address word aligned, incremented, wraps within its 16 Mbyte block.
// - count drops by four each PCI word; transactions up to 16 Mbytes.
// - go refused when count under 16 bytes; software matches processor count.
// - linked-list packet loads only count bits 19 to 2.
// - local address word aligned, all 32 bits kept, never incremented.
// - destination size 00 32-bit, 01 8-bit, 10 16-bit; invert byte order bit.
// - autonomous mode PCI request at 16x watermark, max code 1000, zero cache line.
// - after boundary crossing, local bus request held off 0 to 1024 clocks.
// - back-off starts at 256-byte or 64-byte local boundary per max-burst bit.
// - bursts only when enabled and newer master; four-beat bit forbids partial bursts.
// - stop halts after current transfer, sets stopped; writing 0 resumes.
// - linked list loads control bits 31 to 20; packets all in one memory.
// - go enables transfer and always reads as zero.
// - active reads 1 during a transfer, 0 when idle.
`timescale 1ns/1ps
module dma_chan_ctrl
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	input  wire logic [7:0]  fifo_level,
	input  wire logic [1:0]  cache_line_setting,
	input  wire logic        local_byte_order,
	input  wire logic        newer_master_strap,
	input  wire logic [3:0]  code_lines,
	input  wire logic        single_address_ack,
	input  wire logic        dual_address,
	input  wire logic        end_of_transfer,
	input  wire logic        pci_word_done,
	input  wire logic        local_word_done,
	input  wire logic        bus_xfer_busy,
	input  wire logic        pci_error,
	input  wire logic        local_error,
	input  wire logic        packet_load,
	input  wire logic [31:0] packet_paddr,
	input  wire logic [31:0] packet_count,
	input  wire logic [31:0] packet_laddr,
	input  wire logic [31:0] packet_ctrl,
	output logic             pci_req,
	output logic             local_req,
	output logic             ack_valid,
	output logic             chan_active,
	output logic             to_pci,
	output logic             dma_mode,
	output logic             linked_list,
	output logic             newer_style,
	output logic             own_fast_termination,
	output logic             slave_fast_termination,
	output logic [1:0]       port_size,
	output logic             byte_order_eff,
	output logic             burst_enable,
	output logic             burst_four_only,
	output logic [31:0]      pci_addr,
	output logic [31:0]      local_addr,
	output logic [23:0]      remaining_bytes
);

	typedef struct packed {
		dma_chan_pkg::chan_state_t st;
		logic [31:0] ccs;
		logic [31:0] bec;
		logic [31:0] paddr;
		logic [31:0] cnt;
		logic [31:0] laddr;
		logic [7:0]  lbytes;
		logic [10:0] backoff;
		logic [31:0] rdata;
		logic        preq;
		logic        lreq;
		logic        ack;
	} state_t;

	state_t s_q;
	state_t s_d;

	// watermark in bytes: sixteen per code step, zero falls back to cache line
	function automatic logic [7:0] wm_bytes(input logic [3:0] code, input logic [1:0] cl);
		if (code == 4'h0)
			wm_bytes = {2'h0, cl, 4'h0};
		else
			wm_bytes = {code, 4'h0};
	endfunction

	function automatic logic [10:0] off_clocks(input logic [2:0] code);
		unique case (code)
			3'h0: off_clocks = dma_chan_pkg::OFF_CLK_0;
			3'h1: off_clocks = dma_chan_pkg::OFF_CLK_64;
			3'h2: off_clocks = dma_chan_pkg::OFF_CLK_128;
			3'h3: off_clocks = dma_chan_pkg::OFF_CLK_256;
			3'h4: off_clocks = dma_chan_pkg::OFF_CLK_512;
			3'h5: off_clocks = dma_chan_pkg::OFF_CLK_1024;
			default: off_clocks = dma_chan_pkg::OFF_CLK_0;
		endcase
	endfunction

	// keep the upper byte, advance within the low 24 bits
	function automatic logic [31:0] a24_inc(input logic [31:0] a);
		a24_inc = {a[31:24], a[23:0] + dma_chan_pkg::WORD_BYTES};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic       is_dma;
	logic [7:0] wm;
	logic [3:0] dwm;
	logic [7:0] blk_mask;
	logic       cnt_ok;
	logic       finish;

	always_comb
	begin
		s_d = s_q;
		is_dma = s_q.ccs[dma_chan_pkg::CCS_DMA];
		dwm = s_q.bec[dma_chan_pkg::BEC_WM_LO +: 4];
		if (dwm > dma_chan_pkg::DMA_WM_MAX)
			dwm = dma_chan_pkg::DMA_WM_MAX;
		wm = is_dma ? wm_bytes(dwm, cache_line_setting)
			: wm_bytes(s_q.ccs[dma_chan_pkg::CCS_WM_LO +: 4], cache_line_setting);
		blk_mask = s_q.bec[dma_chan_pkg::BEC_MAXB] ? dma_chan_pkg::BLK_64 : dma_chan_pkg::BLK_256;
		cnt_ok = s_q.cnt[23:0] >= dma_chan_pkg::MIN_COUNT;
		finish = 1'b0;

		// sticky error flags; hardware set beats software clear below
		if (reg_wr && reg_addr == dma_chan_pkg::OFF_CCS)
		begin
			s_d.ccs = (s_q.ccs & ~dma_chan_pkg::CCS_RW_MASK) | (reg_wdata & dma_chan_pkg::CCS_RW_MASK);
			s_d.ccs[dma_chan_pkg::CCS_RSTST] = s_q.ccs[dma_chan_pkg::CCS_RSTST] & ~reg_wdata[dma_chan_pkg::CCS_RSTST];
			s_d.ccs[dma_chan_pkg::CCS_DONE] = s_q.ccs[dma_chan_pkg::CCS_DONE] & ~reg_wdata[dma_chan_pkg::CCS_DONE];
			s_d.ccs[dma_chan_pkg::CCS_PERR] = s_q.ccs[dma_chan_pkg::CCS_PERR] & ~reg_wdata[dma_chan_pkg::CCS_PERR];
			s_d.ccs[dma_chan_pkg::CCS_QERR] = s_q.ccs[dma_chan_pkg::CCS_QERR] & ~reg_wdata[dma_chan_pkg::CCS_QERR];
		end
		if (reg_wr && reg_addr == dma_chan_pkg::OFF_PADDR)
			s_d.paddr = reg_wdata & dma_chan_pkg::ADDR_MASK;
		if (reg_wr && reg_addr == dma_chan_pkg::OFF_CNT)
			s_d.cnt = reg_wdata & dma_chan_pkg::CNT_MASK;
		if (reg_wr && reg_addr == dma_chan_pkg::OFF_LADDR)
			s_d.laddr = reg_wdata & dma_chan_pkg::ADDR_MASK;
		if (reg_wr && reg_addr == dma_chan_pkg::OFF_BEC)
			s_d.bec = (s_q.bec & ~dma_chan_pkg::BEC_RW_MASK) | (reg_wdata & dma_chan_pkg::BEC_RW_MASK);

		if (packet_load && s_q.st != dma_chan_pkg::ST_IDLE && is_dma && s_q.ccs[dma_chan_pkg::CCS_CHAIN])
		begin
			s_d.paddr = packet_paddr & dma_chan_pkg::ADDR_MASK;
			s_d.cnt = packet_count & dma_chan_pkg::LL_CNT_MASK;
			s_d.laddr = packet_laddr & dma_chan_pkg::ADDR_MASK;
			s_d.bec = (s_d.bec & ~dma_chan_pkg::LL_BEC_MASK) | (packet_ctrl & dma_chan_pkg::LL_BEC_MASK);
		end

		if (pci_error && s_q.st != dma_chan_pkg::ST_IDLE)
			s_d.ccs[dma_chan_pkg::CCS_PERR] = 1'b1;
		if (local_error && s_q.st != dma_chan_pkg::ST_IDLE)
			s_d.ccs[dma_chan_pkg::CCS_QERR] = 1'b1;

		if (s_q.backoff != 11'h000)
			s_d.backoff = s_q.backoff - 11'h001;

		unique case (s_q.st)
			dma_chan_pkg::ST_IDLE:
			begin
				s_d.lbytes = 8'h00;
				if (reg_wr && reg_addr == dma_chan_pkg::OFF_CCS && reg_wdata[dma_chan_pkg::CCS_GO] && cnt_ok)
					s_d.st = dma_chan_pkg::ST_RUN;
			end
			dma_chan_pkg::ST_RUN, dma_chan_pkg::ST_STOPPED:
			begin
				if (pci_word_done)
				begin
					s_d.paddr = a24_inc(s_q.paddr);
					s_d.cnt[23:0] = s_q.cnt[23:0] - dma_chan_pkg::WORD_BYTES;
					if (s_q.cnt[23:0] <= dma_chan_pkg::WORD_BYTES)
						finish = 1'b1;
				end
				if (local_word_done && is_dma)
				begin
					s_d.lbytes = s_q.lbytes + 8'h04;
					if (((s_q.lbytes + 8'h04) & blk_mask) == 8'h00)
						s_d.backoff = off_clocks(s_q.bec[dma_chan_pkg::BEC_OFF_LO +: 3]);
				end
				if (end_of_transfer && !is_dma)
					finish = 1'b1;
				if (is_dma && s_q.bec[dma_chan_pkg::BEC_STOP] && !bus_xfer_busy)
					s_d.st = dma_chan_pkg::ST_STOPPED;
				else if (s_q.st == dma_chan_pkg::ST_STOPPED && !s_q.bec[dma_chan_pkg::BEC_STOP])
					s_d.st = dma_chan_pkg::ST_RUN;
				if (finish)
				begin
					s_d.st = dma_chan_pkg::ST_IDLE;
					s_d.ccs[dma_chan_pkg::CCS_DONE] = 1'b1;
				end
				// reset request aborts only while active
				if (reg_wr && reg_addr == dma_chan_pkg::OFF_CCS && reg_wdata[dma_chan_pkg::CCS_RSTREQ])
				begin
					s_d.st = dma_chan_pkg::ST_IDLE;
					s_d.ccs[dma_chan_pkg::CCS_RSTST] = 1'b1;
				end
			end
			default:
				s_d.st = dma_chan_pkg::ST_IDLE;
		endcase

		s_d.ccs[dma_chan_pkg::CCS_ACT] = s_d.st != dma_chan_pkg::ST_IDLE;
		s_d.bec[dma_chan_pkg::BEC_STOPST] = s_d.st == dma_chan_pkg::ST_STOPPED;
		s_d.bec[dma_chan_pkg::BEC_DIR] = s_d.ccs[dma_chan_pkg::CCS_DIR];
		s_d.ccs[dma_chan_pkg::CCS_GO] = 1'b0;
		s_d.ccs[dma_chan_pkg::CCS_RSTREQ] = 1'b0;

		s_d.preq = (s_q.st == dma_chan_pkg::ST_RUN) && (fifo_level >= wm);
		s_d.lreq = (s_q.st == dma_chan_pkg::ST_RUN) && is_dma && (s_q.backoff == 11'h000);
		s_d.ack = (s_q.st == dma_chan_pkg::ST_RUN) && !is_dma && single_address_ack
			&& (!s_q.ccs[dma_chan_pkg::CCS_CODE_EN] || code_lines == s_q.ccs[dma_chan_pkg::CCS_CODE_LO +: 4]);

		s_d.rdata = 32'h00000000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				dma_chan_pkg::OFF_CCS:   s_d.rdata = s_d.ccs;
				dma_chan_pkg::OFF_PADDR: s_d.rdata = s_d.paddr;
				dma_chan_pkg::OFF_CNT:   s_d.rdata = s_d.cnt;
				dma_chan_pkg::OFF_LADDR: s_d.rdata = s_d.laddr;
				dma_chan_pkg::OFF_BEC:   s_d.rdata = s_d.bec;
				default:                 s_d.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////////
	logic [1:0] psz_q;
	logic       boe_q;
	logic       ben_q;
	logic       own_q;
	logic       slv_q;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			psz_q <= dma_chan_pkg::DSZ_32;
			boe_q <= 1'b0;
			ben_q <= 1'b0;
			own_q <= 1'b0;
			slv_q <= 1'b0;
		end
		else
		begin
			if (!s_q.ccs[dma_chan_pkg::CCS_DMA])
				psz_q <= s_q.ccs[dma_chan_pkg::CCS_P16] ? dma_chan_pkg::DSZ_16 : dma_chan_pkg::DSZ_32;
			else
				psz_q <= s_q.bec[dma_chan_pkg::BEC_DSZ_LO +: 2];
			boe_q <= local_byte_order ^ s_q.bec[dma_chan_pkg::BEC_INV];
			ben_q <= s_q.bec[dma_chan_pkg::BEC_BEN] && newer_master_strap && s_q.ccs[dma_chan_pkg::CCS_DMA];
			own_q <= !s_q.ccs[dma_chan_pkg::CCS_STYLE] && s_q.ccs[dma_chan_pkg::CCS_OWNT] && dual_address;
			slv_q <= !s_q.ccs[dma_chan_pkg::CCS_STYLE] && s_q.ccs[dma_chan_pkg::CCS_SLVT] && !dual_address;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign pci_req = s_q.preq;
	assign local_req = s_q.lreq;
	assign ack_valid = s_q.ack;
	assign chan_active = s_q.ccs[dma_chan_pkg::CCS_ACT];
	assign to_pci = s_q.ccs[dma_chan_pkg::CCS_DIR];
	assign dma_mode = s_q.ccs[dma_chan_pkg::CCS_DMA];
	assign linked_list = s_q.ccs[dma_chan_pkg::CCS_CHAIN];
	assign newer_style = s_q.ccs[dma_chan_pkg::CCS_STYLE];
	assign own_fast_termination = own_q;
	assign slave_fast_termination = slv_q;
	assign port_size = psz_q;
	assign byte_order_eff = boe_q;
	assign burst_enable = ben_q;
	assign burst_four_only = s_q.bec[dma_chan_pkg::BEC_B4];
	assign pci_addr = s_q.paddr;
	assign local_addr = s_q.laddr;
	assign remaining_bytes = s_q.cnt[23:0];

endmodule // dma_chan_ctrl

// ===== testbench/dma_chan_ctrl_properties.sv
// Purpose: temporal checks on the channel control ports
// Assumes: outputs are registered and follow their cause by one edge
// Notes:   sees only the top-level ports; bound below
`timescale 1ns/1ps
module dma_chan_ctrl_properties
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        reg_wr,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        end_of_transfer,
	input wire logic        single_address_ack,
	input wire logic        pci_word_done,
	input wire logic        packet_load,
	input wire logic [31:0] packet_count,
	input wire logic        chan_active,
	input wire logic        ack_valid,
	input wire logic        to_pci,
	input wire logic        dma_mode,
	input wire logic        linked_list,
	input wire logic [31:0] pci_addr,
	input wire logic [31:0] local_addr,
	input wire logic [23:0] remaining_bytes
);
	logic ccs_wr;
	logic word;
	assign ccs_wr = reg_wr && reg_addr == dma_chan_pkg::OFF_CCS;
	// register writes and packet loads may legally overwrite the counters
	assign word = chan_active && pci_word_done && !reg_wr && !packet_load;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	AST_GO_REFUSED: assert property (ccs_wr && reg_wdata[31] && !chan_active
		&& remaining_bytes < dma_chan_pkg::MIN_COUNT |=> !chan_active) else $error("go accepted with short count");
	AST_GO_START: assert property (ccs_wr && reg_wdata[31] && !reg_wdata[30] && !chan_active
		&& remaining_bytes >= dma_chan_pkg::MIN_COUNT |=> chan_active) else $error("go did not start");
	AST_CNT_DEC: assert property (word && remaining_bytes > dma_chan_pkg::WORD_BYTES
		|=> remaining_bytes == $past(remaining_bytes) - dma_chan_pkg::WORD_BYTES) else $error("count not reduced by four");
	AST_PADDR_WRAP: assert property (word
		|=> pci_addr == {$past(pci_addr[31:24]), $past(pci_addr[23:0]) + 24'h000004}) else $error("pci address step wrong");
	AST_LADDR_HOLD: assert property (!reg_wr && !packet_load |=> $stable(local_addr))
		else $error("local address moved");
	AST_LAST_WORD: assert property (word && remaining_bytes == dma_chan_pkg::WORD_BYTES |=> !chan_active)
		else $error("channel active after last word");
	AST_EOT_IDLE: assert property (chan_active && end_of_transfer && !dma_mode |=> !chan_active)
		else $error("end of transfer ignored");
	AST_RST_ABORT: assert property (chan_active && ccs_wr && reg_wdata[30] |=> !chan_active)
		else $error("reset request did not abort");
	AST_DIR_COPY: assert property (ccs_wr && !chan_active |=> to_pci == $past(reg_wdata[4]))
		else $error("direction output wrong");
	AST_MODE_SEL: assert property (ccs_wr && !chan_active
		|=> dma_mode == $past(reg_wdata[5]) && linked_list == $past(reg_wdata[6])) else $error("mode outputs wrong");
	AST_ACK_QUALIFIED: assert property (ack_valid
		|-> $past(single_address_ack) && $past(chan_active) && !$past(dma_mode))
		else $error("acknowledge without request");
	AST_LL_COUNT: assert property (packet_load && chan_active && dma_mode && linked_list && !reg_wr
		|=> remaining_bytes == ($past(packet_count[23:0]) & 24'h0FFFFC)) else $error("packet count bits wrong");
endmodule // dma_chan_ctrl_properties

bind dma_chan_ctrl dma_chan_ctrl_properties i_props (.ref_clk, .reset, .reg_wr, .reg_addr, .reg_wdata,
	.end_of_transfer, .single_address_ack, .pci_word_done, .packet_load, .packet_count, .chan_active,
	.ack_valid, .to_pci, .dma_mode,
	.linked_list, .pci_addr, .local_addr, .remaining_bytes);

// ===== testbench/dma_far_side_model.sv
// Purpose: far-side datapath answering the bus request with word strobes
// Assumes: one strobe per 32-bit word; gap sets idle cycles between strobes, never fewer than one
// Notes:   strobes only while the channel is active and asking for the bus
`timescale 1ns/1ps
module dma_far_side_model
(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       en,
	input  wire logic [3:0] gap,
	input  wire logic       pci_req,
	input  wire logic       chan_active,
	output logic            pci_word_done
);
	logic [3:0] wait_cnt = 4'h0;
	initial pci_word_done = 1'b0;
	always @(posedge ref_clk)
	begin
		#2;
		if (!reset && en && pci_req && chan_active && !pci_word_done && wait_cnt >= gap)
		begin
			pci_word_done = 1'b1;
			wait_cnt = 4'h0;
		end
		else
		begin
			pci_word_done = 1'b0;
			wait_cnt = wait_cnt + 4'h1;
		end
	end
endmodule // dma_far_side_model

// ===== testbench/dma_chan_ctrl_tb.sv
// Purpose: self-checking bench for the channel control block
// Assumes: 40 MHz clock; inputs change 2 ns after the rising edge
// Notes:   PCI word strobes come from the far-side model; local word strobes are driven by the bench
`timescale 1ns/1ps
module dma_chan_ctrl_tb;
	logic        ref_clk, reset, reg_wr, reg_rd, lbo, eot, pkt_load, en, quiet;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, pci_addr, local_addr, pkt, rd;
	logic [23:0] remaining_bytes;
	logic [7:0]  fifo_level;
	logic [3:0]  gap, code_in;
	logic        strap, sa_ack, dual, lwd, busy, lreq, ack, ownt, slvt, ben, b4;
	logic [1:0]  port_size;
	logic        pci_word_done, pci_req, chan_active, to_pci, dma_mode, linked_list, newer_style, boe;
	int          err_total, samples_checked;
	always #12.5 ref_clk = ~ref_clk;
	dma_chan_ctrl i_dut (.ref_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .fifo_level,
		.cache_line_setting(2'h1), .local_byte_order(lbo), .newer_master_strap(strap), .code_lines(code_in),
		.single_address_ack(sa_ack), .dual_address(dual), .end_of_transfer(eot), .pci_word_done,
		.local_word_done(lwd), .bus_xfer_busy(busy), .pci_error(quiet), .local_error(quiet),
		.packet_load(pkt_load), .packet_paddr(pkt), .packet_count(pkt), .packet_laddr(pkt), .packet_ctrl(pkt),
		.pci_req, .local_req(lreq), .ack_valid(ack), .chan_active, .to_pci, .dma_mode, .linked_list, .newer_style,
		.own_fast_termination(ownt), .slave_fast_termination(slvt), .port_size, .byte_order_eff(boe),
		.burst_enable(ben), .burst_four_only(b4), .pci_addr, .local_addr, .remaining_bytes);
	dma_far_side_model i_far (.ref_clk, .reset, .en, .gap, .pci_req, .chan_active, .pci_word_done);
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step;
		@(posedge ref_clk);
		#2;
	endtask
	// a spare edge after each access keeps strobes from being reassigned in one step
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		step();
		reg_wr = 1'b0;
		step();
	endtask
	task automatic rdr(input logic [11:0] a);
		reg_rd = 1'b1;
		reg_addr = a;
		step();
		reg_rd = 1'b0;
		rd = reg_rdata;
		step();
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (chan_active === 1'b1 && n < 300)
		begin
			step();
			n++;
		end
		if (n == 300)
		begin
			chk(32'h1, 32'h0);
			finish_test();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		for (int i = 0; i < 6; i++)
		begin
			rdr(12'h400 + 12'(i * 4));
			chk(rd, 32'h0);
		end
		wr(12'h408, 32'hFFFFFFFF);
		rdr(12'h408);
		chk(rd, 32'h00FFFFFC);
		wr(12'h410, 32'hFFFFFFFF);
		rdr(12'h410);
		chk(rd, 32'hF7F7C380);
		wr(12'h410, 32'h0);
		wr(12'h400, 32'h4004FFFF);
		rdr(12'h400);
		chk(rd, 32'h0004FFFF);
		chk({28'h0, dma_mode, linked_list, newer_style, to_pci}, 32'hF);
		wr(12'h400, 32'h0);
		chk({28'h0, dma_mode, linked_list, newer_style, to_pci}, 32'h0);
	endtask
	task automatic t_go_low;
		wr(12'h408, 32'h0000000C);
		wr(12'h400, 32'h80000000);
		chk({31'h0, chan_active}, 32'h0);
		rdr(12'h400);
		chk(rd, 32'h0);
	endtask
	task automatic t_xfer(input logic dir, input logic [3:0] g);
		en = 1'b0;
		gap = g;
		fifo_level = 8'h1F;
		wr(12'h40C, 32'h00ABCDE7);
		wr(12'h404, 32'h12FFFFF8);
		wr(12'h408, 32'h00000020);
		wr(12'h400, 32'h80002000 | {27'h0, dir, 4'h0});
		chk({31'h0, pci_req}, 32'h0);
		fifo_level = 8'h20;
		step();
		step();
		chk({30'h0, pci_req, chan_active}, 32'h3);
		en = 1'b1;
		wait_idle();
		rdr(12'h400);
		chk(rd & 32'h80A00010, {8'h00, 8'h20, 11'h0, dir, 4'h0});
		chk(pci_addr, 32'h12000018);
		chk({8'h0, remaining_bytes}, 32'h0);
		chk({31'h0, to_pci}, {31'h0, dir});
		rdr(12'h40C);
		chk(rd, 32'h00ABCDE4);
		wr(12'h400, 32'h00200000);
		en = 1'b0;
	endtask
	task automatic t_abort;
		wr(12'h408, 32'h00000040);
		wr(12'h400, 32'h80000000);
		eot = 1'b1;
		step();
		eot = 1'b0;
		step();
		rdr(12'h400);
		chk(rd & 32'h00E00000, 32'h00200000);
		wr(12'h408, 32'h00000040);
		wr(12'h400, 32'h80200000);
		wr(12'h400, 32'h40000000);
		rdr(12'h400);
		chk(rd & 32'hC0C00000, 32'h00400000);
		wr(12'h400, 32'h00600000);
	endtask
	task automatic t_idma;
		code_in = 4'h9;
		sa_ack = 1'b1;
		dual = 1'b1;
		wr(12'h408, 32'h00000040);
		// code 9 with matching on, older style, both fast terminations, narrow port
		wr(12'h400, 32'h80000987);
		chk({26'h0, ack, ownt, slvt, newer_style, port_size}, 32'h32);
		code_in = 4'h3;
		dual = 1'b0;
		step();
		chk({26'h0, ack, ownt, slvt, newer_style, port_size}, 32'h0A);
		wr(12'h400, 32'h0000000E);
		chk({26'h0, ack, ownt, slvt, newer_style, port_size}, 32'h24);
		sa_ack = 1'b0;
		eot = 1'b1;
		step();
		eot = 1'b0;
		step();
		chk({31'h0, chan_active}, 32'h0);
		wr(12'h400, 32'h00200000);
	endtask
	task automatic t_stop;
		strap = 1'b1;
		wr(12'h400, 32'h00000020);
		wr(12'h408, 32'h00000040);
		// 64-clock hold-off, 64-byte boundary, four-beat bursts
		wr(12'h410, 32'h0001C200);
		chk({30'h0, ben, b4}, 32'h3);
		wr(12'h400, 32'h80000020);
		chk({31'h0, lreq}, 32'h1);
		lwd = 1'b1;
		repeat (15) step();
		chk({31'h0, lreq}, 32'h1);
		step();
		lwd = 1'b0;
		step();
		chk({31'h0, lreq}, 32'h0);
		repeat (63) step();
		chk({31'h0, lreq}, 32'h0);
		step();
		chk({31'h0, lreq}, 32'h1);
		// stop must wait for the bus transfer in flight
		busy = 1'b1;
		wr(12'h410, 32'h0001C280);
		rdr(12'h410);
		chk(rd & 32'h00000040, 32'h0);
		busy = 1'b0;
		step();
		rdr(12'h410);
		chk(rd & 32'h00000040, 32'h00000040);
		chk({31'h0, lreq}, 32'h0);
		wr(12'h410, 32'h0001C200);
		rdr(12'h410);
		chk(rd & 32'h00000040, 32'h0);
		wr(12'h400, 32'h40000020);
		wr(12'h400, 32'h00400000);
		strap = 1'b0;
	endtask
	task automatic t_dma;
		lbo = 1'b1;
		wr(12'h400, 32'h00000060);
		for (int c = 0; c < 3; c++)
		begin
			wr(12'h410, (32'(c) << 25) | 32'h01000000);
			chk({30'h0, port_size}, 32'(c));
			chk({31'h0, boe}, 32'h0);
		end
		// packets are only taken while a linked-list transfer runs
		wr(12'h408, 32'h00000040);
		wr(12'h400, 32'h80000060);
		pkt = 32'hFFFFFFFF;
		pkt_load = 1'b1;
		step();
		pkt_load = 1'b0;
		step();
		chk({8'h0, remaining_bytes}, 32'h000FFFFC);
		rdr(12'h410);
		chk(rd & 32'hF7F00000, 32'hF7F00000);
		wr(12'h400, 32'h40000060);
		chk({31'h0, chan_active}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		reset = 1'b1;
		{reg_wr, reg_rd, lbo, eot, pkt_load, en, quiet} = 7'h00;
		{strap, sa_ack, dual, lwd, busy} = 5'h00;
		code_in = 4'h0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		pkt = 32'h0;
		fifo_level = 8'h00;
		gap = 4'h0;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge ref_clk);
		#2;
		reset = 1'b0;
		t_regs();
		t_go_low();
		t_xfer(1'b0, 4'h0);
		t_xfer(1'b1, 4'h5);
		t_abort();
		t_idma();
		t_stop();
		t_dma();
		finish_test();
	end
endmodule // dma_chan_ctrl_tb
